// *** tb/bsc_bidir_cell_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsc_bidir_cell_bench;
    import bsc_pkg::*;

    logic        clk          = 1'h0;
    logic        arst_n       = 1'h0;
    logic        inPathSysInN = 1'h1;
    logic        inPathSel    = 1'h0;
    logic        outPathSysIn = 1'h0;
    logic        outPathSel   = 1'h0;
    logic        hsel         = 1'h0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'h0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hwdata       = 32'h0;
    logic [31:0] rd;
    int          failures     = 0;
    int          cmp_count    = 0;
    wire  logic  testClk, testClkGate, scanShift, updateN, inPathScanIn, outPathScanIn;
    wire  logic  inPathParOut, inPathScanOut, outPathParOut, outPathScanOut, hreadyout, hresp;
    wire  logic [31:0] hrdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz
    always #4 clk = ~clk;

    // Cell and its test controller
    bsc_bidir_cell dut (.clk(clk), .arst_n(arst_n), .testClk(testClk),
        .testClkGate(testClkGate), .scanShift(scanShift), .updateN(updateN),
        .inPathSysInN(inPathSysInN), .inPathScanIn(inPathScanIn), .inPathSel(inPathSel),
        .inPathParOut(inPathParOut), .inPathScanOut(inPathScanOut),
        .outPathSysIn(outPathSysIn), .outPathScanIn(outPathScanIn), .outPathSel(outPathSel),
        .outPathParOut(outPathParOut), .outPathScanOut(outPathScanOut), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    bsc_tap_model tap (.clk(clk), .testClk(testClk), .testClkGate(testClkGate),
        .scanShift(scanShift), .updateN(updateN), .inPathScanIn(inPathScanIn),
        .outPathScanIn(outPathScanIn));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic tally_and_finish();
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Compare helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic chkb(input string nm, input logic seen, input logic exp);
        chk(nm, {31'h0, seen}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Bus master: waits for hready under a bound
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                failures++;
                tally_and_finish();
            end
        end while (hreadyout !== 1'h1);
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // System data to the parallel outputs with both selects low, input path inverted
    task automatic t_parallel();
        for (int v = 0; v < 2; v++) begin
            inPathSysInN <= v[0];
            outPathSysIn <= v[0];
            cyc(6);
            chkb("inPathParOut", inPathParOut, ~v[0]);
            chkb("outPathParOut", outPathParOut, v[0]);
        end
    endtask

    // Shift, update, then shift again while latches hold
    task automatic t_shift();
        tap.pulse(1'h1, 1'h1, 1'h1, 1'h1);
        chkb("inPathScanOut", inPathScanOut, 1'h1);
        chkb("outPathScanOut", outPathScanOut, 1'h1);
        tap.set_update(1'h0);
        tap.set_update(1'h1);
        inPathSel    <= 1'h1;
        outPathSel   <= 1'h1;
        outPathSysIn <= 1'h0;
        cyc(6);
        chkb("inPathParOut", inPathParOut, 1'h1);
        chkb("outPathParOut", outPathParOut, 1'h1);
        tap.pulse(1'h1, 1'h1, 1'h0, 1'h0);
        chkb("inPathScanOut", inPathScanOut, 1'h0);
        chkb("inPathParOut", inPathParOut, 1'h1);
        chkb("outPathParOut", outPathParOut, 1'h1);
        ahb(1'h0, BSC_STATUS_OFF, 32'h0);
        chk("status", {26'h0, rd[5:0]}, 32'h3c);
    endtask

    // Capture from latch, pad and core data
    task automatic t_capture();
        outPathSysIn <= 1'h1;
        tap.pulse(1'h1, 1'h0, 1'h0, 1'h0);
        chkb("inPathScanOut", inPathScanOut, 1'h1);
        chkb("outPathScanOut", outPathScanOut, 1'h1);
        inPathSel    <= 1'h0;
        outPathSel   <= 1'h0;
        outPathSysIn <= 1'h0;
        tap.pulse(1'h1, 1'h0, 1'h1, 1'h1);
        chkb("inPathScanOut", inPathScanOut, 1'h0);
        chkb("outPathScanOut", outPathScanOut, 1'h0);
        chkb("outPathParOut", outPathParOut, 1'h0);
    endtask

    // Gate low freezes the flops; edge counter over the bus
    task automatic t_gate();
        ahb(1'h1, BSC_CTRL_OFF, 32'h1);
        ahb(1'h0, BSC_EDGES_OFF, 32'h0);
        chk("edges", rd, 32'h0);
        tap.pulse(1'h0, 1'h1, 1'h1, 1'h1);
        chkb("inPathScanOut", inPathScanOut, 1'h0);
        chkb("outPathScanOut", outPathScanOut, 1'h0);
        repeat (3) tap.pulse(1'h1, 1'h1, 1'h0, 1'h1);
        chkb("outPathScanOut", outPathScanOut, 1'h1);
        ahb(1'h0, BSC_EDGES_OFF, 32'h0);
        chk("edges", rd, 32'h3);
        ahb(1'h0, 32'h0000_000c, 32'h0);
        chk("unmapped", rd, 32'h0);
        chkb("hresp", hresp, 1'h0);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        cyc(4);
        t_parallel();
        t_shift();
        t_capture();
        t_gate();
        tally_and_finish();
    end
endmodule // bsc_bidir_cell_bench
`default_nettype wire

// *** tb/bsc_tap_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsc_tap_model (
    // Clock
    input  wire logic clk,
    // Scan controls toward the cell
    output var  logic testClk,
    output var  logic testClkGate,
    output var  logic scanShift,
    output var  logic updateN,
    // Serial data toward the cell
    output var  logic inPathScanIn,
    output var  logic outPathScanIn
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels: test clock stands still low, latches holding
    initial begin
        testClk       = 1'h0;
        testClkGate   = 1'h0;
        scanShift     = 1'h0;
        updateN       = 1'h1;
        inPathScanIn  = 1'h0;
        outPathScanIn = 1'h0;
    end

    // One 64 ns test clock period: 3 clk low with controls set, 4 clk high, 1 clk low
    task automatic pulse(input logic gate, input logic shift, input logic d0, input logic d1);
        testClkGate   <= gate;
        scanShift     <= shift;
        inPathScanIn  <= d0;
        outPathScanIn <= d1;
        repeat (3) @(posedge clk);
        testClk <= 1'h1;
        repeat (4) @(posedge clk);
        // Falling edge with flipped serial data: must not load
        testClk       <= 1'h0;
        inPathScanIn  <= ~d0;
        outPathScanIn <= ~d1;
        @(posedge clk);
    endtask

    // Update control, opened only between shift sequences
    task automatic set_update(input logic openN);
        updateN <= openN;
        repeat (4) @(posedge clk);
    endtask
endmodule // bsc_tap_model
`default_nettype wire

// *** verilog/bsc_bidir_cell.sv ***
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - With the input-path select low, the input parallel output is the inverse of the pad data.
// - With the input-path select high, the input parallel output shows the input hold latch.
// - With the output-path select low, the output parallel output follows the core data as is.
// - With the output-path select high, the output parallel output shows the output hold latch.
// - On capture, the input scan flop loads inverted pad data, or the hold latch when selected.
// - On shift, each scan flop loads its own serial input.
// - With the clock gate low, both scan flops keep their values on a test clock edge.
// - Scan flops change only on a rising test clock edge and hold otherwise.
// - The input hold latch passes the input scan flop while update is low and holds when high.
// - On capture, the output scan flop loads the core data whatever the select.
// - The output hold latch passes the output scan flop while update is low, holds when high.
// - There is no asynchronous set; state changes only by capture, shift and update.
// - Capture and shift act on the rising test clock edge, controls set up before it.
module bsc_bidir_cell
    import bsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Test controller pins
    input  wire logic        testClk,
    input  wire logic        testClkGate,
    input  wire logic        scanShift,
    input  wire logic        updateN,
    // Input half of the pad
    input  wire logic        inPathSysInN,
    input  wire logic        inPathScanIn,
    input  wire logic        inPathSel,
    output logic             inPathParOut,
    output logic             inPathScanOut,
    // Output half of the pad
    input  wire logic        outPathSysIn,
    input  wire logic        outPathScanIn,
    input  wire logic        outPathSel,
    output logic             outPathParOut,
    output logic             outPathScanOut,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp
);
    import bsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    bsc_pins_s pinsRaw;
    bsc_pins_s pinsSync;

    // Bundle the pins for the crossing
    always_comb begin
        pinsRaw.testClk       = testClk;
        pinsRaw.testClkGate   = testClkGate;
        pinsRaw.scanShift     = scanShift;
        pinsRaw.updateN       = updateN;
        pinsRaw.inPathSysInN  = inPathSysInN;
        pinsRaw.inPathScanIn  = inPathScanIn;
        pinsRaw.inPathSel     = inPathSel;
        pinsRaw.outPathSysIn  = outPathSysIn;
        pinsRaw.outPathScanIn = outPathScanIn;
        pinsRaw.outPathSel    = outPathSel;
    end

    bsc_sync u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .pinsRaw  (pinsRaw),
        .pinsSync (pinsSync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Scan cell: scan flops, hold latches, parallel outputs

    logic tckPrev_r;
    logic tckPrev_nxt;
    logic inScan_r;
    logic inScan_nxt;
    logic outScan_r;
    logic outScan_nxt;
    logic inHoldN_r;
    logic inHoldN_nxt;
    logic outHold_r;
    logic outHold_nxt;
    logic inPar_nxt;
    logic outPar_nxt;
    logic tckRise;
    logic scanTake;

    // Edge finder on the sampled test clock
    assign tckRise  = pinsSync.testClk & ~tckPrev_r;
    assign scanTake = tckRise & pinsSync.testClkGate;

    // Next state of the cell; no asynchronous set path exists
    always_comb begin
        tckPrev_nxt = pinsSync.testClk;
        inScan_nxt  = inScan_r;
        outScan_nxt = outScan_r;
        inHoldN_nxt = inHoldN_r;
        outHold_nxt = outHold_r;
        // Scan flops move only on a gated rising edge
        if (scanTake) begin
            if (pinsSync.scanShift) begin
                inScan_nxt  = pinsSync.inPathScanIn;
                outScan_nxt = pinsSync.outPathScanIn;
            end else begin
                inScan_nxt  = pinsSync.inPathSel ? inHoldN_r : ~pinsSync.inPathSysInN;
                outScan_nxt = pinsSync.outPathSysIn;
            end
        end
        // Hold latches follow the scan flops while update is low
        if (!pinsSync.updateN) begin
            inHoldN_nxt = inScan_r;
            outHold_nxt = outScan_r;
        end
        // Parallel output selection
        inPar_nxt  = pinsSync.inPathSel ? inHoldN_r : ~pinsSync.inPathSysInN;
        outPar_nxt = pinsSync.outPathSel ? outHold_r : pinsSync.outPathSysIn;
    end

    // Cell registers; system reset only, no set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tckPrev_r     <= BSC_BIT_RST;
            inScan_r      <= BSC_BIT_RST;
            outScan_r     <= BSC_BIT_RST;
            inHoldN_r     <= BSC_BIT_RST;
            outHold_r     <= BSC_BIT_RST;
            inPathParOut  <= BSC_BIT_RST;
            outPathParOut <= BSC_BIT_RST;
        end else begin
            tckPrev_r     <= tckPrev_nxt;
            inScan_r      <= inScan_nxt;
            outScan_r     <= outScan_nxt;
            inHoldN_r     <= inHoldN_nxt;
            outHold_r     <= outHold_nxt;
            inPathParOut  <= inPar_nxt;
            outPathParOut <= outPar_nxt;
        end
    end

    // Serial outputs are the scan flops themselves
    assign inPathScanOut  = inScan_r;
    assign outPathScanOut = outScan_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Taken-edge counter

    logic [15:0] edges_r;
    logic [15:0] edges_nxt;
    logic        edgeClr;

    // Clear from software; a taken edge in the same cycle still counts
    always_comb begin
        edges_nxt = edges_r;
        if (edgeClr) begin
            edges_nxt = BSC_EDGES_RST;
        end
        if (scanTake) begin
            edges_nxt = edgeClr ? 16'h0001 : 16'(edges_r + 16'h0001);
        end
    end

    // Counter register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edges_r <= BSC_EDGES_RST;
        end else begin
            edges_r <= edges_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states, always OKAY

    logic        wrPend_r;
    logic        wrPend_nxt;
    logic [7:0]  wrAddr_r;
    logic [7:0]  wrAddr_nxt;
    logic [31:0] hrdata_nxt;
    logic        addrTake;
    logic [31:0] statusWord;

    // Status word from the cell state
    function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [31:0] st,
                                              input logic [15:0] cnt);
        logic [31:0] val;
        val = BSC_WORD_RST;
        if (addr == BSC_STATUS_OFF[7:0]) begin
            val = st;
        end else if (addr == BSC_EDGES_OFF[7:0]) begin
            val = {16'h0000, cnt};
        end
        return val;
    endfunction

    always_comb begin
        statusWord                  = BSC_WORD_RST;
        statusWord[BSC_ST_IN_SCAN]  = inScan_r;
        statusWord[BSC_ST_OUT_SCAN] = outScan_r;
        statusWord[BSC_ST_IN_HOLD]  = inHoldN_r;
        statusWord[BSC_ST_OUT_HOLD] = outHold_r;
        statusWord[BSC_ST_IN_PAR]   = inPathParOut;
        statusWord[BSC_ST_OUT_PAR]  = outPathParOut;
        statusWord[BSC_ST_GATE]     = pinsSync.testClkGate;
        statusWord[BSC_ST_SHIFT]    = pinsSync.scanShift;
        statusWord[BSC_ST_UPDATE_N] = pinsSync.updateN;
    end

    assign addrTake = hsel & htrans[1] & hready;

    // Address phase decode, data phase write
    always_comb begin
        wrPend_nxt = addrTake & hwrite;
        wrAddr_nxt = addrTake ? (haddr[7:0] & BSC_ADDR_MASK) : wrAddr_r;
        hrdata_nxt = hrdata;
        if (addrTake && !hwrite) begin
            hrdata_nxt = (haddr[31:8] == 24'h000000)
                       ? read_word(haddr[7:0] & BSC_ADDR_MASK, statusWord, edges_r)
                       : BSC_WORD_RST;
        end
        edgeClr = wrPend_r & (wrAddr_r == BSC_CTRL_OFF[7:0]) & hwdata[BSC_CTRL_CLR_BIT];
    end

    // Bus registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_r  <= BSC_BIT_RST;
            wrAddr_r  <= 8'h00;
            hrdata    <= BSC_WORD_RST;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrPend_r  <= wrPend_nxt;
            wrAddr_r  <= wrAddr_nxt;
            hrdata    <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    chk_in_sys_pass: assert property (
        !pinsSync.inPathSel |=> inPathParOut == !$past(pinsSync.inPathSysInN))
        else $error("input parallel output not inverted pad data");

    chk_in_hold_pass: assert property (
        pinsSync.inPathSel ##1 pinsSync.inPathSel |=> inPathParOut == $past(inHoldN_r))
        else $error("input parallel output not hold latch");

    chk_out_sys_pass: assert property (
        !pinsSync.outPathSel |=> outPathParOut == $past(pinsSync.outPathSysIn))
        else $error("output parallel output not core data");

    chk_out_hold_pass: assert property (
        pinsSync.outPathSel |=> outPathParOut == $past(outHold_r))
        else $error("output parallel output not hold latch");

    chk_in_capture_val: assert property (
        scanTake && !pinsSync.scanShift
        |=> inPathScanOut == ($past(pinsSync.inPathSel) ? $past(inHoldN_r)
                                                        : !$past(pinsSync.inPathSysInN)))
        else $error("input scan flop captured wrong value");

    chk_shift_both: assert property (
        scanTake && pinsSync.scanShift
        |=> inPathScanOut == $past(pinsSync.inPathScanIn)
            && outPathScanOut == $past(pinsSync.outPathScanIn))
        else $error("scan flops did not shift serial inputs");

    chk_gate_freeze: assert property (
        !pinsSync.testClkGate [*2] |=> $stable(inPathScanOut) && $stable(outPathScanOut))
        else $error("scan flop moved with clock gate low");

    chk_no_edge_hold: assert property (
        !tckRise |=> $stable(inScan_r) && $stable(outScan_r))
        else $error("scan flop moved without rising test clock");

    chk_in_latch_path: assert property (
        pinsSync.updateN |=> $stable(inHoldN_r))
        else $error("input hold latch moved while update high");

    chk_out_capture_val: assert property (
        scanTake && !pinsSync.scanShift |=> outPathScanOut == $past(pinsSync.outPathSysIn))
        else $error("output scan flop captured wrong value");

    chk_out_latch_path: assert property (
        !pinsSync.updateN |=> outHold_r == $past(outScan_r))
        else $error("output hold latch not transparent");

    chk_rise_once: assert property (
        tckRise == $rose(pinsSync.testClk))
        else $error("rising test clock edge missed or doubled");

endmodule // bsc_bidir_cell
`default_nettype wire

// *** verilog/bsc_pkg.sv ***
`default_nettype none
package bsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses on the AHB-Lite slave
    localparam logic [31:0] BSC_STATUS_OFF = 32'h0000_0000;
    localparam logic [31:0] BSC_EDGES_OFF  = 32'h0000_0004;
    localparam logic [31:0] BSC_CTRL_OFF   = 32'h0000_0008;
    localparam logic [7:0]  BSC_ADDR_MASK  = 8'hfc;

    // Control register fields
    localparam int          BSC_CTRL_CLR_BIT = 0;

    // Status register field positions
    localparam int BSC_ST_IN_SCAN   = 0;
    localparam int BSC_ST_OUT_SCAN  = 1;
    localparam int BSC_ST_IN_HOLD   = 2;
    localparam int BSC_ST_OUT_HOLD  = 3;
    localparam int BSC_ST_IN_PAR    = 4;
    localparam int BSC_ST_OUT_PAR   = 5;
    localparam int BSC_ST_GATE      = 6;
    localparam int BSC_ST_SHIFT     = 7;
    localparam int BSC_ST_UPDATE_N  = 8;

    // Reset values
    localparam logic        BSC_BIT_RST   = 1'b0;
    localparam logic [15:0] BSC_EDGES_RST = 16'h0000;
    localparam logic [31:0] BSC_WORD_RST  = 32'h0000_0000;

    // Cycle counts
    localparam int BSC_SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Pins coming from the test controller and the pad
    typedef struct packed {
        logic testClk;
        logic testClkGate;
        logic scanShift;
        logic updateN;
        logic inPathSysInN;
        logic inPathScanIn;
        logic inPathSel;
        logic outPathSysIn;
        logic outPathScanIn;
        logic outPathSel;
    } bsc_pins_s;

    localparam bsc_pins_s BSC_PINS_RST = '0;

endpackage
`default_nettype wire

// *** verilog/bsc_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsc_sync
    import bsc_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      arst_n,
    // Raw pins and their synchronised copy
    input  wire bsc_pins_s pinsRaw,
    output var  bsc_pins_s pinsSync
);
    import bsc_pkg::*;

    bsc_pins_s stage1_r;
    bsc_pins_s stage1_nxt;
    bsc_pins_s stage2_nxt;

    // Next values: first stage feeds only the second
    always_comb begin
        stage1_nxt = pinsRaw;
        stage2_nxt = stage1_r;
    end

    // Two-flop synchroniser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= BSC_PINS_RST;
            pinsSync <= BSC_PINS_RST;
        end else begin
            stage1_r <= stage1_nxt;
            pinsSync <= stage2_nxt;
        end
    end

endmodule // bsc_sync
`default_nettype wire
